// [shared/mdp_pkg.sv]
// Shared constants and carrier types of the multiport memory front end.
// Assumes one memory clock (sys_clk) for all ports and the controller face.
`default_nettype none
package mdp_pkg;
  // Memory word and address widths
  localparam int DATA_W = 256;
  localparam int ADDR_W = 32;
  // Number of reader ports, outstanding read cap, tag FIFO depth
  localparam int NUM_RD = 2;
  localparam int RD_DEPTH = 128;
  localparam int TAG_DEPTH = 256;
  // Words a client should keep spare beyond the read cap
  localparam int AFULL_MARGIN = 8;
  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] TAGC_OFS = 8'h08;
  // Control register layout and reset value
  localparam int CTRL_EN_BIT = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  // Status register field positions
  localparam int STAT_GRANT_LSB = 0;
  localparam int STAT_WBUSY_BIT = 8;
  localparam int STAT_CMDV_BIT = 9;
  // Command toward the controller command FIFO
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } mdp_cmd_t;
  // Reader port request group from a client
  typedef struct packed {
    logic strobe;
    logic abort;
    logic [ADDR_W-1:0] first;
    logic [ADDR_W-1:0] last;
    logic [ADDR_W-1:0] low;
    logic [ADDR_W-1:0] high;
  } mdp_rdreq_t;
  // First and last word markers
  typedef struct packed {
    logic first;
    logic last;
  } mdp_flags_t;
endpackage
`default_nettype wire

// [hdl/mdp_reader.sv]
// One reader port: turns a strobed address range into read commands.
// Assumes the top grants it through cmd_take and returns tagged data.
`default_nettype none
module mdp_reader
  import mdp_pkg::*;
#(
  parameter int DEPTH = RD_DEPTH
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic port_reset,
  input wire mdp_rdreq_t req,
  input wire logic afull,
  input wire logic cmd_take,
  output logic cmd_req,
  output logic [ADDR_W-1:0] cmd_addr,
  output mdp_flags_t cmd_flags,
  input wire logic ret_valid,
  input wire logic [DATA_W-1:0] ret_data,
  input wire mdp_flags_t ret_flags,
  output logic [DATA_W-1:0] read_data,
  output logic read_wr,
  output logic read_first,
  output logic read_last,
  output logic read_sent,
  output logic read_done
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  typedef enum logic {RD_IDLE, RD_RUN} mdp_rdst_t;
  mdp_rdst_t state_q, state_d; // Issue state
  logic [ADDR_W-1:0] addr_q, addr_d, last_q, last_d, low_q, low_d, high_q, high_d;
  logic first_q, first_d; // Next command opens the operation
  logic [CW-1:0] cnt_q, cnt_d; // Outstanding reads
  logic sent_q, sent_d, done_q, done_d;
  logic [DATA_W-1:0] data_q, data_d;
  logic wr_q, wr_d, fst_q, fst_d, lst_q, lst_d;

  assign cmd_req = (state_q == RD_RUN) && !afull && !req.abort && (cnt_q < DEPTH_C);
  assign cmd_addr = addr_q;
  assign cmd_flags = '{first: first_q, last: (addr_q == last_q)};

  // Next state of the issue side and the output stage
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    last_d = last_q;
    low_d = low_q;
    high_d = high_q;
    first_d = first_q;
    cnt_d = cnt_q;
    // Outstanding count: up per command, down per returned word
    if (cmd_take) begin
      cnt_d = cnt_d + CW'(1);
    end
    if (ret_valid && (cnt_q != '0)) begin
      cnt_d = cnt_d - CW'(1);
    end
    case (state_q)
      RD_IDLE: begin
        if (req.strobe) begin
          state_d = RD_RUN;
          addr_d = req.first;
          last_d = req.last;
          low_d = req.low;
          high_d = req.high;
          first_d = 1'b1;
        end
      end
      RD_RUN: begin
        if (req.abort) begin
          // Abort stops further commands
          state_d = RD_IDLE;
        end else if (cmd_take) begin
          first_d = 1'b0;
          if (addr_q == last_q) begin
            state_d = RD_IDLE;
          end else if (addr_q == high_q) begin
            addr_d = low_q;
          end else begin
            addr_d = addr_q + ADDR_W'(1);
          end
        end
      end
      default: state_d = RD_IDLE;
    endcase
    if (port_reset) begin
      state_d = RD_IDLE;
      first_d = 1'b0;
      cnt_d = '0;
    end
    sent_d = (state_d == RD_IDLE);
    done_d = (state_d == RD_IDLE) && (cnt_d == '0);
    wr_d = ret_valid && !port_reset;
    data_d = ret_valid ? ret_data : data_q;
    fst_d = ret_valid && ret_flags.first && !port_reset;
    lst_d = ret_valid && ret_flags.last && !port_reset;
  end

  // Register all state
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= RD_IDLE;
      addr_q <= '0;
      last_q <= '0;
      low_q <= '0;
      high_q <= '0;
      first_q <= 1'b0;
      cnt_q <= '0;
      sent_q <= 1'b1;
      done_q <= 1'b1;
      data_q <= '0;
      wr_q <= 1'b0;
      fst_q <= 1'b0;
      lst_q <= 1'b0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      last_q <= last_d;
      low_q <= low_d;
      high_q <= high_d;
      first_q <= first_d;
      cnt_q <= cnt_d;
      sent_q <= sent_d;
      done_q <= done_d;
      data_q <= data_d;
      wr_q <= wr_d;
      fst_q <= fst_d;
      lst_q <= lst_d;
    end
  end

  assign read_data = data_q;
  assign read_wr = wr_q;
  assign read_first = fst_q;
  assign read_last = lst_q;
  assign read_sent = sent_q;
  assign read_done = done_q;

  // Checks of the reader port
  sequence last_issue_s;
    cmd_take && (addr_q == last_q) && !req.abort && !port_reset;
  endsequence
  depth_cap_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cnt_q <= DEPTH_C) else $error("reader outstanding count over cap");
  afull_stop_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    afull |-> !cmd_req) else $error("reader issued under almost full");
  sent_after_last_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    last_issue_s |=> read_sent) else $error("sent missing after last command");
  wrap_low_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cmd_take && !req.abort && !port_reset && (addr_q == high_q) && (addr_q != last_q)
    |=> (addr_q == $past(low_q))) else $error("reader did not wrap to low");
  data_valid_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (ret_valid && !port_reset) |=> (read_wr && (read_data == $past(ret_data))))
    else $error("returned word not presented");
  first_mark_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    read_first |-> read_wr) else $error("first marker without valid word");
  last_mark_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (ret_valid && ret_flags.last && !port_reset) |=> read_last)
    else $error("last marker missing");
  done_idle_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    read_done |-> (read_sent && (cnt_q == '0))) else $error("done with reads pending");
endmodule
`default_nettype wire

// [hdl/mdp_top.sv]
// Multiport front end: one writer port, NRD reader ports, priority command
// mux, tag FIFO for returned reads and a small AHB-Lite register slave.
// Assumes the controller command FIFO answers cmd_ready and returns one
// 256-bit word per read command, in order, on rd_valid.
//
// Behaviour
// - Read and write data buses 256 bits
// - Read valid strobe marks valid words
// - First-word marker on first read word
// - Last-word marker on final read word
// - Almost full stops further read commands
// - 32-bit write addresses, wrap last to first
// - Writer done once write completes
// - Write-last ends operation, otherwise keeps wrapping
// - Take-data output marks captured word
// - Strict fixed priority command grant
// - Higher priority switches select, accepted next
// - One 256-bit word per command
// - Ports walk whole requested address range
// - Tag pushed with each read command
// - Popped tag routes returned word
// - Tag carries first and last flags
// - Outstanding reads capped per port
// - Reader wraps high back to low
// - Sent once commands issued, restrobe allowed
// - Done after all data delivered
`default_nettype none
module mdp_top
  import mdp_pkg::*;
#(
  parameter int NRD = NUM_RD,
  parameter int RDEP = RD_DEPTH,
  parameter int TDEP = TAG_DEPTH
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Writer port
  input wire logic write_reset,
  input wire logic write_strobe,
  input wire logic [ADDR_W-1:0] write_first_addr,
  input wire logic [ADDR_W-1:0] write_last_addr,
  input wire logic [DATA_W-1:0] write_data,
  input wire logic write_last,
  input wire logic write_empty,
  output logic write_take,
  output logic write_done,
  // Reader ports
  input wire logic [NRD-1:0] read_reset,
  input wire mdp_rdreq_t [NRD-1:0] read_req,
  input wire logic [NRD-1:0] read_afull,
  output logic [NRD-1:0][DATA_W-1:0] read_data,
  output logic [NRD-1:0] read_valid,
  output logic [NRD-1:0] read_firstdata,
  output logic [NRD-1:0] read_lastdata,
  output logic [NRD-1:0] read_sent,
  output logic [NRD-1:0] read_done,
  // Controller face
  output mdp_cmd_t cmd,
  output logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic rd_valid,
  input wire logic [DATA_W-1:0] rd_data
);
  localparam int NP = NRD + 1; // Port 0 writer, then readers
  localparam int SW = $clog2(NP);
  localparam int TW = $clog2(NRD) > 0 ? $clog2(NRD) : 1;
  localparam int PW = $clog2(TDEP);
  typedef struct packed {
    logic [TW-1:0] port;
    mdp_flags_t flags;
  } mdp_tag_t;
  typedef enum logic {WR_IDLE, WR_RUN} mdp_wrst_t;

  // Highest priority requester; lowest index wins
  function automatic logic [SW-1:0] mdp_pick(input logic [NP-1:0] r);
    logic [SW-1:0] p;
    p = '0;
    for (int i = NP - 1; i >= 0; i--) begin
      if (r[i]) begin
        p = SW'(i);
      end
    end
    return p;
  endfunction

  logic [NP-1:0] req; // Per-port command requests
  logic [NRD-1:0][ADDR_W-1:0] rd_addr;
  mdp_flags_t [NRD-1:0] rd_flags;
  logic [NRD-1:0] rd_take, rd_ret;
  logic [SW-1:0] sel_q, sel_d; // Selection register
  logic take; // Granted port hands over a command
  logic [31:0] ctrl_q, ctrl_d; // Control register
  mdp_cmd_t cmd_q, cmd_d;
  logic cmdv_q, cmdv_d;
  mdp_tag_t ctag_q, ctag_d; // Tag riding with the staged command
  mdp_wrst_t wst_q, wst_d;
  logic [ADDR_W-1:0] waddr_q, waddr_d, wfirst_q, wfirst_d, wlast_q, wlast_d;
  logic wtake_q, wtake_d, wdone_q, wdone_d;
  mdp_tag_t tag_mem [TDEP]; // Tag FIFO storage
  logic [PW-1:0] twp_q, twp_d, trp_q, trp_d;
  logic [PW:0] tcnt_q, tcnt_d;
  logic tpush, tpop;
  mdp_tag_t tag_out;
  logic ap_q, ap_d, apw_q, apw_d; // Pending AHB data phase
  logic [7:0] apa_q, apa_d;
  logic [31:0] hrd_q, hrd_d;

  // Writer requests only with data and no take pulse pending
  assign req[0] = (wst_q == WR_RUN) && !write_empty && !wtake_q;
  // Accept when enabled and the staging slot frees
  assign take = ctrl_q[CTRL_EN_BIT] && req[sel_q] && (!cmdv_q || cmd_ready);
  assign tpush = cmdv_q && cmd_ready && !cmd_q.write;
  assign tpop = rd_valid && (tcnt_q != '0);
  assign tag_out = tag_mem[trp_q];

  // Reader ports
  for (genvar g = 0; g < NRD; g++) begin : g_rd
    assign rd_take[g] = take && (sel_q == SW'(g + 1));
    assign rd_ret[g] = tpop && (tag_out.port == TW'(g));
    mdp_reader #(.DEPTH(RDEP)) u_rd (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .port_reset(read_reset[g]),
      .req(read_req[g]),
      .afull(read_afull[g]),
      .cmd_take(rd_take[g]),
      .cmd_req(req[g + 1]),
      .cmd_addr(rd_addr[g]),
      .cmd_flags(rd_flags[g]),
      .ret_valid(rd_ret[g]),
      .ret_data(rd_data),
      .ret_flags(tag_out.flags),
      .read_data(read_data[g]),
      .read_wr(read_valid[g]),
      .read_first(read_firstdata[g]),
      .read_last(read_lastdata[g]),
      .read_sent(read_sent[g]),
      .read_done(read_done[g])
    );
  end

  // Arbiter, command stage and writer port
  always_comb begin
    sel_d = sel_q;
    if ((req != '0) && ((mdp_pick(req) < sel_q) || !req[sel_q])) begin
      sel_d = mdp_pick(req);
    end
    cmd_d = cmd_q;
    cmdv_d = cmdv_q && !cmd_ready;
    ctag_d = ctag_q;
    if (take) begin
      cmdv_d = 1'b1;
      if (sel_q == '0) begin
        cmd_d = '{write: 1'b1, addr: waddr_q, data: write_data};
      end else begin
        cmd_d = '{write: 1'b0, addr: rd_addr[sel_q - SW'(1)], data: '0};
        ctag_d = '{port: TW'(sel_q - SW'(1)), flags: rd_flags[sel_q - SW'(1)]};
      end
    end
    wst_d = wst_q;
    waddr_d = waddr_q;
    wfirst_d = wfirst_q;
    wlast_d = wlast_q;
    wdone_d = wdone_q;
    wtake_d = take && (sel_q == '0);
    case (wst_q)
      WR_IDLE: begin
        if (write_strobe) begin
          wst_d = WR_RUN;
          waddr_d = write_first_addr;
          wfirst_d = write_first_addr;
          wlast_d = write_last_addr;
          wdone_d = 1'b0;
        end
      end
      WR_RUN: begin
        if (take && (sel_q == '0)) begin
          if (write_last) begin
            wst_d = WR_IDLE;
            wdone_d = 1'b1;
          end else if (waddr_q == wlast_q) begin
            waddr_d = wfirst_q;
          end else begin
            waddr_d = waddr_q + ADDR_W'(1);
          end
        end
      end
      default: wst_d = WR_IDLE;
    endcase
    if (write_reset) begin
      wst_d = WR_IDLE;
      wdone_d = 1'b0;
      wtake_d = 1'b0;
    end
    // Tag FIFO pointers
    twp_d = tpush ? twp_q + PW'(1) : twp_q;
    trp_d = tpop ? trp_q + PW'(1) : trp_q;
    tcnt_d = tcnt_q + (PW + 1)'(tpush) - (PW + 1)'(tpop);
  end

  // AHB-Lite slave: zero wait, always OKAY
  always_comb begin
    ap_d = hsel && hready && htrans[1];
    apw_d = hwrite;
    apa_d = haddr[7:0];
    ctrl_d = ctrl_q;
    hrd_d = hrd_q;
    // Write lands in the data phase
    if (ap_q && apw_q && (apa_q == CTRL_OFS)) begin
      ctrl_d = hwdata;
    end
    // Read data fetched at the address phase
    if (ap_d && !hwrite) begin
      case (haddr[7:0])
        CTRL_OFS: hrd_d = ctrl_q;
        STAT_OFS: begin
          hrd_d = '0;
          hrd_d[STAT_GRANT_LSB +: SW] = sel_q;
          hrd_d[STAT_WBUSY_BIT] = (wst_q == WR_RUN);
          hrd_d[STAT_CMDV_BIT] = cmdv_q;
        end
        TAGC_OFS: hrd_d = 32'(tcnt_q);
        default: hrd_d = '0;
      endcase
    end
  end

  // Register all state except the tag storage
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_q <= '0;
      cmd_q <= '0;
      cmdv_q <= 1'b0;
      ctag_q <= '0;
      wst_q <= WR_IDLE;
      waddr_q <= '0;
      wfirst_q <= '0;
      wlast_q <= '0;
      wtake_q <= 1'b0;
      wdone_q <= 1'b0;
      twp_q <= '0;
      trp_q <= '0;
      tcnt_q <= '0;
      ap_q <= 1'b0;
      apw_q <= 1'b0;
      apa_q <= '0;
      ctrl_q <= CTRL_RST;
      hrd_q <= '0;
    end else begin
      sel_q <= sel_d;
      cmd_q <= cmd_d;
      cmdv_q <= cmdv_d;
      ctag_q <= ctag_d;
      wst_q <= wst_d;
      waddr_q <= waddr_d;
      wfirst_q <= wfirst_d;
      wlast_q <= wlast_d;
      wtake_q <= wtake_d;
      wdone_q <= wdone_d;
      twp_q <= twp_d;
      trp_q <= trp_d;
      tcnt_q <= tcnt_d;
      ap_q <= ap_d;
      apw_q <= apw_d;
      apa_q <= apa_d;
      ctrl_q <= ctrl_d;
      hrd_q <= hrd_d;
    end
  end

  // Tag storage, no reset needed
  always_ff @(posedge sys_clk) begin
    if (tpush) begin
      tag_mem[twp_q] <= ctag_q;
    end
  end

  assign cmd = cmd_q;
  assign cmd_valid = cmdv_q;
  assign write_take = wtake_q;
  assign write_done = wdone_q;
  assign hrdata = hrd_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Checks of the arbiter, tag FIFO and writer
  priority_grant_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (req != '0) && (mdp_pick(req) < sel_q) |=> (sel_q == $past(mdp_pick(req))))
    else $error("select did not move to higher port");
  grant_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    req[sel_q] && (mdp_pick(req) >= sel_q) |=> $stable(sel_q))
    else $error("grant changed without higher request");
  tag_push_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (cmd_valid && cmd_ready && !cmd.write) |=> (tcnt_q == $past(tcnt_q) + 1'b1)
    || $past(tpop)) else $error("read command without tag");
  write_wrap_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    take && (sel_q == '0) && !write_last && !write_reset && (waddr_q == wlast_q)
    |=> (waddr_q == wfirst_q)) else $error("writer did not wrap");
  take_pulse_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    write_take |=> !write_take) else $error("take pulse longer than one cycle");
  empty_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    write_empty && !write_reset |=> !write_take) else $error("writer took data while empty");
  write_done_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    take && (sel_q == '0) && write_last && !write_reset |=> write_done)
    else $error("writer done missing");
endmodule
`default_nettype wire

// [verif/mdp_ctrl_model.sv]
// Memory controller stand-in: logs commands, returns one word per read.
// Assumes commands stay valid until cmd_ready and reads return in order.
`default_nettype none
module mdp_ctrl_model
  import mdp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic slow,
  input wire mdp_cmd_t cmd,
  input wire logic cmd_valid,
  output logic cmd_ready,
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // Accepted commands, for the bench
  mdp_cmd_t log[$];
  // Read addresses waiting for data
  logic [ADDR_W-1:0] pend[$];
  // Accept, queue and return reads
  // one word per command
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_ready <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= '0;
      pend = {};
    end else begin
      // Slow mode stalls every other cycle
      cmd_ready <= slow ? ~cmd_ready : 1'b1;
      if (pend.size() > 0 && !(slow && cmd_ready)) begin
        rd_valid <= 1'b1;
        rd_data <= {8{pend.pop_front() ^ 32'h5a5a_0000}};
      end else begin
        rd_valid <= 1'b0;
        // Idle data line keeps changing
        rd_data <= ~rd_data;
      end
      if (cmd_valid && cmd_ready) begin
        log.push_back(cmd);
        if (!cmd.write) pend.push_back(cmd.addr);
      end
    end
  end
endmodule
`default_nettype wire

// [verif/multiport_dram_ports_test.sv]
// Self-checking bench: register slave, writer, two readers, priority.
// Assumes the controller model of mdp_ctrl_model on the command face.
`default_nettype none
module multiport_dram_ports_test
  import mdp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, reset_n = 0, hsel = 0, hwrite = 0, slow = 0;
  logic write_reset = 0, write_strobe = 0, write_last = 0, write_empty = 1;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, wfirst = '0, wlast = '0;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, write_take, write_done, cmd_valid, cmd_ready, rd_valid;
  logic [DATA_W-1:0] write_data = '0, rd_data;
  logic [1:0] read_reset = '0, read_afull = '0, read_valid, read_first, read_lastd;
  logic [1:0] read_sent, read_done;
  logic [1:0][DATA_W-1:0] read_data;
  mdp_rdreq_t [1:0] rq = '0;
  mdp_cmd_t cmd;
  int mismatches = 0, checks = 0;
  // Clock of 100 ns
  always #50 sys_clk = ~sys_clk;
  mdp_top #(.NRD(2)) uut (.sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .write_reset(write_reset), .write_strobe(write_strobe),
    .write_first_addr(wfirst), .write_last_addr(wlast), .write_data(write_data),
    .write_last(write_last), .write_empty(write_empty), .write_take(write_take),
    .write_done(write_done), .read_reset(read_reset), .read_req(rq),
    .read_afull(read_afull), .read_data(read_data), .read_valid(read_valid),
    .read_firstdata(read_first), .read_lastdata(read_lastd), .read_sent(read_sent),
    .read_done(read_done), .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .rd_valid(rd_valid), .rd_data(rd_data));
  mdp_ctrl_model mdl (.sys_clk(sys_clk), .reset_n(reset_n), .slow(slow), .cmd(cmd),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rd_valid(rd_valid),
    .rd_data(rd_data));
  // Verdict and end of run
  task automatic stop_test;
    if (mismatches == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Compare and count
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen[31:0], exp[31:0]);
    end
  endtask
  // Wait that ran out ends the run
  task automatic tmo(input bit ok);
    if (!ok) begin
      mismatches++;
      $display("CHECK FAILED at %0t: wait timed out", $time);
      stop_test();
    end
  endtask
  // Expected words
  function automatic logic [DATA_W-1:0] mem_word(input logic [31:0] a);
    return {8{a ^ 32'h5a5a_0000}};
  endfunction
  function automatic logic [DATA_W-1:0] wr_word(input int k);
    return {8{32'h1000 + k}};
  endfunction
  // One AHB-Lite single transfer
  task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    int i;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge sys_clk);
      i++;
    end while (hreadyout !== 1'b1 && i < 100);
    tmo(i < 100);
    r = hrdata;
    // Select stays up; idle htrans closes the transfer
  endtask
  // Strobe a read range into one port
  task automatic rd_start(input int p, input logic [31:0] f, l, lo, hi);
    rq[p].first <= f;
    rq[p].last <= l;
    rq[p].low <= lo;
    rq[p].high <= hi;
    rq[p].strobe <= 1'b1;
    @(posedge sys_clk);
    rq[p].strobe <= 1'b0;
  endtask
  // Gather n words on port p and judge each
  // words leave at once, margin unused
  task automatic rd_collect(input int p, input logic [31:0] f, lo, hi, input int n);
    logic [31:0] a;
    int k, i;
    a = f;
    k = 0;
    for (i = 0; i < 400 && !(k == n && read_done[p]); i++) begin
      @(posedge sys_clk);
      if (read_valid[p]) begin
        chk(read_data[p], mem_word(a));
        chk(read_first[p], k == 0);
        chk(read_lastd[p], k == n - 1);
        chk(read_valid[1 - p], 1'b0);
        a = (a == hi) ? lo : a + 1;
        k++;
      end
    end
    tmo(i < 400);
    chk(k, n);
    chk(read_sent[p], 1'b1);
  endtask
  // Register slave: reset value, write, unmapped place
  task automatic sc_regs;
    logic [31:0] r;
    ahb(1'b0, 32'(CTRL_OFS), '0, r);
    chk(r, CTRL_RST);
    ahb(1'b0, 32'h40, '0, r);
    chk(r, 32'h0);
    ahb(1'b1, 32'(CTRL_OFS), 32'h0, r);
    ahb(1'b0, 32'(CTRL_OFS), '0, r);
    chk(r, 32'h0);
    ahb(1'b1, 32'(CTRL_OFS), 32'h1, r);
    chk(hresp, 1'b0);
  endtask
  // Writer: four words over three addresses, wrap, then last
  task automatic sc_write;
    int n, i, b;
    b = mdl.log.size();
    wfirst <= 32'h10;
    wlast <= 32'h12;
    write_strobe <= 1'b1;
    write_data <= wr_word(0);
    write_empty <= 1'b0;
    @(posedge sys_clk);
    write_strobe <= 1'b0;
    n = 0;
    for (i = 0; i < 200 && n < 4; i++) begin
      @(posedge sys_clk);
      if (write_take) begin
        n++;
        write_data <= wr_word(n);
        write_last <= (n == 3);
        write_empty <= (n == 4);
      end
    end
    tmo(n == 4);
    for (i = 0; i < 20 && mdl.log.size() < b + 4; i++) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
    chk(write_done, 1'b1);
    chk(write_take, 1'b0);
    chk(mdl.log.size(), b + 4);
    for (i = 0; i < 4; i++) begin
      chk(mdl.log[b + i].addr, (i == 3) ? 32'h10 : 32'h10 + i);
      chk(mdl.log[b + i].data, wr_word(i));
    end
  endtask
  // Reader two with stalling controller and range wrap
  task automatic sc_read_route;
    slow <= 1'b1;
    rd_start(1, 32'h6, 32'h5, 32'h4, 32'h7);
    rd_collect(1, 32'h6, 32'h4, 32'h7, 4);
    slow <= 1'b0;
  endtask
  // Almost full holds commands back; port reset clears the range
  task automatic sc_afull_reset;
    int b;
    b = mdl.log.size();
    read_afull[0] <= 1'b1;
    rd_start(0, 32'h0, 32'h3, 32'h0, 32'hf);
    repeat (20) @(posedge sys_clk);
    chk(mdl.log.size(), b);
    read_reset[0] <= 1'b1;
    @(posedge sys_clk);
    read_reset[0] <= 1'b0;
    read_afull[0] <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(read_sent[0], 1'b1);
    chk(mdl.log.size(), b);
    rd_start(0, 32'h20, 32'h22, 32'h20, 32'h2f);
    rd_collect(0, 32'h20, 32'h20, 32'h2f, 3);
    // Abort drops a strobed range before any command
    b = mdl.log.size();
    rq[0].abort <= 1'b1;
    rd_start(0, 32'h30, 32'h3f, 32'h30, 32'h3f);
    repeat (4) @(posedge sys_clk);
    rq[0].abort <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk(read_done[0], 1'b1);
    chk(mdl.log.size(), b);
  endtask
  // Low reader starts, high reader strobes a cycle later and takes over
  task automatic sc_priority;
    int b, i;
    logic [31:0] r;
    logic [31:0] ord [6];
    ord = '{32'h200, 32'h100, 32'h101, 32'h102, 32'h201, 32'h202};
    b = mdl.log.size();
    rq[0].first <= 32'h100;
    rq[0].last <= 32'h102;
    rq[1].first <= 32'h200;
    rq[1].last <= 32'h202;
    rq[1].strobe <= 1'b1;
    @(posedge sys_clk);
    rq[1].strobe <= 1'b0;
    rq[0].strobe <= 1'b1;
    @(posedge sys_clk);
    rq[0].strobe <= 1'b0;
    for (i = 0; i < 300 && !(mdl.log.size() == b + 6 && &read_done); i++)
      @(posedge sys_clk);
    tmo(i < 300);
    chk(mdl.log[b + 1].addr, 32'h100);
    for (i = 0; i < 6; i++)
      chk(mdl.log[b + i].addr, ord[i]);
    // Grant stays on the last reader, tag FIFO drained
    ahb(1'b0, 32'(STAT_OFS), '0, r);
    chk(r, 32'h2);
    ahb(1'b0, 32'(TAGC_OFS), '0, r);
    chk(r, 32'h0);
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    sc_regs();
    sc_write();
    sc_read_route();
    sc_afull_reset();
    rq[0].low <= 32'h0;
    rq[0].high <= 32'hfff;
    rq[1].low <= 32'h0;
    rq[1].high <= 32'hfff;
    sc_priority();
    stop_test();
  end
endmodule
`default_nettype wire
